// ===== design/wcm_pkg.sv
package wcm_pkg;

   localparam int LOWFREQ_HZ     = 31000;
   localparam int BASE_PERIOD_US = 4000;
   localparam int BASE_EDGES     = LOWFREQ_HZ * BASE_PERIOD_US / 1000000;
   localparam int BASE_W         = $clog2(BASE_EDGES);
   localparam int POST_W         = 16;
   localparam int TAP_W          = 4;
   localparam int MCLK_HZ        = 20000000;
   localparam int MCLK_PERIOD_NS = 1000000000 / MCLK_HZ;

   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] REG_OSC_CTRL   = 2'h0;
   localparam logic [ADDR_W-1:0] REG_WDT_SOFT   = 2'h1;
   localparam logic [ADDR_W-1:0] REG_INT_STATUS = 2'h2;
   localparam logic [ADDR_W-1:0] REG_INT_MASK   = 2'h3;

   localparam int IFS_LSB  = 4;
   localparam int IFS_W    = 3;
   localparam int OSC_STARTUP_DONE_FLAG_BIT = 3;
   localparam int SCS_LSB  = 0;
   localparam int SCS_W    = 2;
   localparam int SWDT_BIT = 0;
   localparam int INT_W        = 2;
   localparam int INT_OSC_FAIL = 0;
   localparam int INT_WDT      = 1;

   localparam logic [IFS_W-1:0] IFS_RST = 3'h4;
   localparam logic [SCS_W-1:0] SCS_RST = 2'h0;

   localparam int PIN_LF   = 0;
   localparam int PIN_PRIM = 1;
   localparam int PIN_SEC  = 2;
   localparam int PIN_W    = 3;

   typedef enum logic [2:0] {
      MODE_LOW_POWER_CRYSTAL,
      MODE_STANDARD_CRYSTAL,
      MODE_HIGH_SPEED_CRYSTAL,
      MODE_HIGH_SPEED_CRYSTAL_PLL,
      MODE_EXTERNAL_CLOCK,
      MODE_EXTERNAL_RES_CAP,
      MODE_INTERNAL_LOWFREQ
   } wcm_osc_mode_t;

   typedef enum logic [1:0] {
      CLK_PRIMARY,
      CLK_SECONDARY,
      CLK_INTERNAL
   } wcm_clk_src_t;

   typedef enum logic [1:0] {
      PM_RUN,
      PM_IDLE,
      PM_SLEEP
   } wcm_pm_t;

   typedef struct packed {
      wcm_osc_mode_t    osc_mode;
      logic             wdt_cfg_en;
      logic [TAP_W-1:0] wdt_tap;
      logic             clock_fail_monitor_cfg_en;
   } wcm_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } wcm_bus_t;

   function automatic logic is_crystal(wcm_osc_mode_t m);
      return m inside {MODE_LOW_POWER_CRYSTAL, MODE_STANDARD_CRYSTAL,
                       MODE_HIGH_SPEED_CRYSTAL, MODE_HIGH_SPEED_CRYSTAL_PLL};
   endfunction : is_crystal

   function automatic wcm_clk_src_t scs_to_src(logic [SCS_W-1:0] s);
      if (s[1]) begin
         return CLK_INTERNAL;
      end
      return s[0] ? CLK_SECONDARY : CLK_PRIMARY;
   endfunction : scs_to_src

   function automatic logic [POST_W-1:0] tap_limit(logic [TAP_W-1:0] t);
      return ~({POST_W{1'b1}} << t);
   endfunction : tap_limit

endpackage : wcm_pkg

// ===== design/wcm_sync.sv
`timescale 1ns/10ps
module wcm_sync
   import wcm_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } wcm_sync_state_t;

   wcm_sync_state_t r;
   wcm_sync_state_t next_r;

   always_comb begin
      next_r.stage1 = d;
      next_r.stage2 = r.stage1;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.stage2;
endmodule : wcm_sync

// ===== design/wcm_wdt_count.sv
`timescale 1ns/10ps
module wcm_wdt_count
   import wcm_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             run,
   input  wire logic             lf_edge,
   input  wire logic             clear,
   input  wire logic [TAP_W-1:0] tap,
   output logic                  timeout
);
   typedef struct packed {
      logic [BASE_W-1:0] base;
      logic [POST_W-1:0] post;
      logic              timeout;
   } wcm_cnt_state_t;

   wcm_cnt_state_t r;
   wcm_cnt_state_t next_r;

   always_comb begin
      next_r = r;
      next_r.timeout = 1'b0;
      if (clear || !run) begin
         next_r.base = '0;
         next_r.post = '0;
      end else if (lf_edge) begin
         if (r.base == BASE_W'(BASE_EDGES - 1)) begin
            next_r.base = '0;
            if (r.post == tap_limit(tap)) begin
               next_r.post = '0;
               next_r.timeout = 1'b1;
            end else begin
               next_r.post = r.post + 1'b1;
            end
         end else begin
            next_r.base = r.base + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign timeout = r.timeout;
endmodule : wcm_wdt_count

// ===== design/wcm_watchdog_monitor.sv
`timescale 1ns/10ps
module wcm_watchdog_monitor
   import wcm_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire wcm_bus_t          bus,
   output logic      [DATA_W-1:0] rdata,
   input  wire wcm_cfg_t          cfg,
   input  wire logic              internal_lowfreq_rc,
   input  wire logic              primary_clk,
   input  wire logic              secondary_clk,
   input  wire wcm_pm_t           pm_mode,
   input  wire logic              sleep_instr,
   input  wire logic              clear_watchdog_instr,
   input  wire logic              wake_event,
   input  wire logic              ost_done,
   input  wire logic              pll_done,
   output logic                   lowfreq_osc_en,
   output logic                   primary_osc_en,
   output wcm_clk_src_t           clk_src,
   output logic                   cpu_resume,
   output logic                   wdt_reset,
   output logic                   wdt_wake,
   output logic                   irq
);
   typedef enum logic [1:0] {
      ST_START,
      ST_MONITOR,
      ST_FAILED
   } wcm_state_t;

   typedef struct packed {
      wcm_state_t        st;
      logic [IFS_W-1:0]  ifs;
      logic [SCS_W-1:0]  scs;
      logic              osc_startup_done_flag;
      logic              swdt;
      logic [INT_W-1:0]  status;
      logic [INT_W-1:0]  mask;
      logic [DATA_W-1:0] rdata;
      wcm_clk_src_t      src;
      logic              prim_en;
      logic              lf_en;
      logic              lf_prev;
      logic              prim_prev;
      logic              sec_prev;
      logic              seen;
      logic              fail;
      logic              held;
      logic              cpu_resume;
      logic              wdt_reset;
      logic              wdt_wake;
      wcm_pm_t           pm_prev;
   } wcm_mon_state_t;

   localparam wcm_mon_state_t MON_RST = '{
      st:         ST_START,
      ifs:        IFS_RST,
      scs:        SCS_RST,
      osc_startup_done_flag:       1'b0,
      swdt:       1'b0,
      status:     '0,
      mask:       '0,
      rdata:      '0,
      src:        CLK_INTERNAL,
      prim_en:    1'b1,
      lf_en:      1'b0,
      lf_prev:    1'b0,
      prim_prev:  1'b0,
      sec_prev:   1'b0,
      seen:       1'b0,
      fail:       1'b0,
      held:       1'b0,
      cpu_resume: 1'b0,
      wdt_reset:  1'b0,
      wdt_wake:   1'b0,
      pm_prev:    PM_RUN
   };

   wcm_mon_state_t   p;
   wcm_mon_state_t   n;
   logic [PIN_W-1:0] pins_q;
   logic             lf_edge;
   logic             mon_edge;
   logic             mon_active;
   logic             fail_det;
   logic             fail_hold;
   logic             wdt_run;
   logic             wd_clear;
   logic             wd_timeout;
   logic             osc_wr;
   logic             ifs_chg;
   logic             wake_sleep;
   logic             pm_entry;
   logic             start_done;
   wcm_clk_src_t     wr_src;

   wcm_sync #(
      .W (PIN_W)
   ) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .d    ({secondary_clk, primary_clk, internal_lowfreq_rc}),
      .q    (pins_q)
   );

   wcm_wdt_count u_count (
      .mclk    (mclk),
      .rst     (rst),
      .run     (wdt_run),
      .lf_edge (lf_edge),
      .clear   (wd_clear),
      .tap     (cfg.wdt_tap),
      .timeout (wd_timeout)
   );

   // Decoded events
   always_comb begin
      lf_edge    = pins_q[PIN_LF] & ~p.lf_prev;
      mon_edge   = (p.src == CLK_SECONDARY) ?
                   (pins_q[PIN_SEC] ^ p.sec_prev) :
                   (pins_q[PIN_PRIM] ^ p.prim_prev);
      mon_active = cfg.clock_fail_monitor_cfg_en && (p.st == ST_MONITOR) &&
                   (pm_mode != PM_SLEEP) && (p.src != CLK_INTERNAL);
      fail_det   = lf_edge && mon_active && !p.seen;
      fail_hold  = (pm_mode == PM_IDLE) && !p.mask[INT_OSC_FAIL];
      wdt_run    = cfg.wdt_cfg_en | p.swdt;
      osc_wr     = bus.wr && (bus.addr == REG_OSC_CTRL);
      ifs_chg    = osc_wr && (bus.wdata[IFS_LSB +: IFS_W] != p.ifs);
      wd_clear   = sleep_instr | clear_watchdog_instr | ifs_chg |
                   p.fail;
      wake_sleep = (p.pm_prev == PM_SLEEP) && (pm_mode != PM_SLEEP);
      pm_entry   = (p.pm_prev == PM_RUN) && (pm_mode == PM_IDLE);
      wr_src     = scs_to_src(bus.wdata[SCS_LSB +: SCS_W]);
      start_done = !is_crystal(cfg.osc_mode) ||
                   (ost_done && (pll_done ||
                    cfg.osc_mode != MODE_HIGH_SPEED_CRYSTAL_PLL));
   end

   // Next state
   always_comb begin
      n            = p;
      n.rdata      = '0;
      n.fail       = 1'b0;
      n.cpu_resume = 1'b0;
      n.wdt_reset  = 1'b0;
      n.wdt_wake   = 1'b0;
      n.pm_prev    = pm_mode;
      n.lf_prev    = pins_q[PIN_LF];
      n.prim_prev  = pins_q[PIN_PRIM];
      n.sec_prev   = pins_q[PIN_SEC];
      n.lf_en      = wdt_run | cfg.clock_fail_monitor_cfg_en;

      // Register writes
      if (bus.wr) begin
         unique case (bus.addr)
            REG_OSC_CTRL: begin
               n.ifs = bus.wdata[IFS_LSB +: IFS_W];
               n.scs = bus.wdata[SCS_LSB +: SCS_W];
            end
            REG_WDT_SOFT: begin
               n.swdt = bus.wdata[SWDT_BIT];
            end
            REG_INT_STATUS: begin
               n.status = p.status & ~bus.wdata[INT_W-1:0];
            end
            REG_INT_MASK: begin
               n.mask = bus.wdata[INT_W-1:0];
            end
         endcase
      end

      // Register reads, one cycle later
      if (bus.rd) begin
         unique case (bus.addr)
            REG_OSC_CTRL: begin
               n.rdata[IFS_LSB +: IFS_W] = p.ifs;
               n.rdata[OSC_STARTUP_DONE_FLAG_BIT]         = p.osc_startup_done_flag;
               n.rdata[SCS_LSB +: SCS_W] = p.scs;
            end
            REG_WDT_SOFT: begin
               n.rdata[SWDT_BIT] = p.swdt;
            end
            REG_INT_STATUS: begin
               n.rdata[INT_W-1:0] = p.status;
            end
            REG_INT_MASK: begin
               n.rdata[INT_W-1:0] = p.mask;
            end
         endcase
      end

      // Edge presence of the monitored clock per sample period
      if (lf_edge) begin
         n.seen = mon_edge;
      end else begin
         n.seen = p.seen | mon_edge;
      end

      // Start-up, power-managed selection
      unique case (p.st)
         ST_START: begin
            // First sample window counts as seen once monitoring starts
            n.seen = 1'b1;
            if (wake_sleep) begin
               n.prim_en = 1'b1;
            end
            if (osc_wr && wr_src != CLK_PRIMARY) begin
               n.prim_en = 1'b0;
               n.src     = wr_src;
               n.st      = ST_MONITOR;
            end else if (start_done) begin
               n.st   = ST_MONITOR;
               n.src  = CLK_PRIMARY;
               n.osc_startup_done_flag = 1'b1;
            end else begin
               n.src = CLK_INTERNAL;
            end
         end
         ST_MONITOR: begin
            if (wake_sleep) begin
               n.st      = ST_START;
               n.osc_startup_done_flag    = 1'b0;
               n.src     = CLK_INTERNAL;
               n.prim_en = 1'b1;
               n.seen    = 1'b0;
            end else if (pm_entry) begin
               n.src = scs_to_src(p.scs);
            end else if (osc_wr && pm_mode == PM_RUN) begin
               n.src = wr_src;
            end
         end
         ST_FAILED: begin
            n.src = p.src;
         end
      endcase

      // Sleep stops the primary oscillator
      if (pm_mode == PM_SLEEP && p.pm_prev != PM_SLEEP) begin
         n.prim_en = 1'b0;
      end

      // Clock failure, set wins over clear
      if (fail_det) begin
         n.fail                 = 1'b1;
         n.st                   = ST_FAILED;
         n.status[INT_OSC_FAIL] = 1'b1;
         if (fail_hold) begin
            n.held = 1'b1;
            n.src  = p.src;
         end else begin
            n.src = CLK_INTERNAL;
         end
      end

      if (p.held && wake_event) begin
         n.held       = 1'b0;
         n.src        = CLK_INTERNAL;
         n.cpu_resume = 1'b1;
      end

      // Watchdog terminal count
      if (wd_timeout) begin
         n.status[INT_WDT] = 1'b1;
         if (pm_mode == PM_SLEEP) begin
            n.wdt_wake = 1'b1;
         end else begin
            n.wdt_reset = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         p <= MON_RST;
      end else begin
         p <= n;
      end
   end

   assign rdata          = p.rdata;
   assign lowfreq_osc_en = p.lf_en;
   assign primary_osc_en = p.prim_en;
   assign clk_src        = p.src;
   assign cpu_resume     = p.cpu_resume;
   assign wdt_reset      = p.wdt_reset;
   assign wdt_wake       = p.wdt_wake;
   assign irq            = |(p.status & p.mask);

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   lf_enable_a: assert property (
      (cfg.wdt_cfg_en || p.swdt) |=> lowfreq_osc_en)
      else $error("watchdog on without low-frequency oscillator");

   soft_enable_a: assert property (
      (bus.wr && bus.addr == REG_WDT_SOFT && !bus.wdata[SWDT_BIT] &&
       !cfg.wdt_cfg_en) |=> !wdt_run)
      else $error("software enable cleared but watchdog still runs");

   cfg_enable_a: assert property (
      cfg.wdt_cfg_en |-> wdt_run)
      else $error("configuration enable ignored");

   clear_counts_a: assert property (
      wd_clear |=> !wd_timeout [*2])
      else $error("watchdog timed out right after a clear");

   timeout_reset_a: assert property (
      (wd_timeout && pm_mode != PM_SLEEP) |=> wdt_reset && !wdt_wake)
      else $error("timeout while awake did not reset");

   timeout_wake_a: assert property (
      (wd_timeout && pm_mode == PM_SLEEP) |=> wdt_wake && !wdt_reset)
      else $error("timeout while asleep did not wake");

   pm_entry_a: assert property (
      (pm_entry && p.st == ST_MONITOR && !fail_det && !wake_sleep)
      |=> clk_src == scs_to_src($past(p.scs)))
      else $error("power-managed entry did not select source");

   fail_switch_a: assert property (
      (fail_det && !fail_hold) |=> clk_src == CLK_INTERNAL &&
      p.status[INT_OSC_FAIL] ##1 p.st == ST_FAILED)
      else $error("failure did not switch to internal clock");

   no_return_a: assert property (
      (p.st == ST_FAILED && clk_src == CLK_INTERNAL)
      |=> clk_src == CLK_INTERNAL)
      else $error("switched back to a failed source");

   idle_resume_a: assert property (
      (p.held && wake_event) |=> cpu_resume && clk_src == CLK_INTERNAL
      ##1 !cpu_resume)
      else $error("wake after idle failure not on internal clock");

   immediate_mon_a: assert property (
      (p.st == ST_START && !is_crystal(cfg.osc_mode))
      |=> p.st == ST_MONITOR)
      else $error("monitoring delayed for non-crystal mode");

   start_internal_a: assert property (
      (p.st == ST_START && !start_done && !osc_wr)
      |=> clk_src == CLK_INTERNAL && !p.osc_startup_done_flag)
      else $error("crystal start-up not on internal clock");

   start_quiet_a: assert property (
      p.st == ST_START |=> !$rose(p.status[INT_OSC_FAIL]))
      else $error("failure flagged during crystal start-up");

   pm_disable_a: assert property (
      (p.st == ST_START && osc_wr && wr_src != CLK_PRIMARY)
      |=> !primary_osc_en)
      else $error("primary kept on after new mode in start-up");

   irq_level_a: assert property (
      $rose(p.status[INT_OSC_FAIL]) && p.mask[INT_OSC_FAIL] |-> irq)
      else $error("unmasked failure without interrupt");

endmodule : wcm_watchdog_monitor

// ===== sim/wcm_osc_model.sv
`timescale 1ns/10ps
module wcm_osc_model (
   input  wire logic mclk,
   input  wire logic prim_run,
   output logic      lf_rc,
   output logic      prim_clk,
   output logic      sec_clk
);
   logic [1:0] div;

   initial begin
      div      = 2'h0;
      lf_rc    = 1'b0;
      prim_clk = 1'b0;
      sec_clk  = 1'b0;
   end

   always @(posedge mclk) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
         lf_rc <= ~lf_rc;
      end
      // A failed primary sticks at its last level
      prim_clk <= prim_run ? ~prim_clk : prim_clk;
      sec_clk  <= div[0] ? ~sec_clk : sec_clk;
   end
endmodule : wcm_osc_model

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb
   import wcm_pkg::*;
;
   logic mclk = 1'b0, rst = 1'b1, prim_run = 1'b1;
   logic lf, prim, sec, ost_done = 1'b0, pll_done = 1'b1;
   logic sleep_i = 1'b0, clr_i = 1'b0, wake_i = 1'b0;
   logic lf_q = 1'b0;
   logic        lf_en, prim_en, resume, w_rst, w_wake, irq;
   logic [7:0]  rdata, d;
   wcm_bus_t     bus = '0;
   wcm_cfg_t     cfg = '{MODE_EXTERNAL_CLOCK, 1'b0, 4'h0, 1'b0};
   wcm_pm_t      pm = PM_RUN;
   wcm_clk_src_t src;
   int error_cnt = 0, check_count = 0, cyc = 0;
   int lf_cnt = 0, n_rst = 0, n_wake = 0, n_res = 0;

   always #25 mclk = ~mclk;

   wcm_osc_model i_osc (.mclk(mclk), .prim_run(prim_run), .lf_rc(lf),
      .prim_clk(prim), .sec_clk(sec));

   wcm_watchdog_monitor i_dut (.mclk(mclk), .rst(rst), .bus(bus),
      .rdata(rdata), .cfg(cfg), .internal_lowfreq_rc(lf),
      .primary_clk(prim), .secondary_clk(sec), .pm_mode(pm),
      .sleep_instr(sleep_i), .clear_watchdog_instr(clr_i),
      .wake_event(wake_i), .ost_done(ost_done), .pll_done(pll_done),
      .lowfreq_osc_en(lf_en), .primary_osc_en(prim_en), .clk_src(src),
      .cpu_resume(resume), .wdt_reset(w_rst), .wdt_wake(w_wake),
      .irq(irq));

   always @(posedge mclk) begin
      lf_q <= lf;
      lf_cnt <= lf_cnt + int'(lf & ~lf_q);
      n_rst <= n_rst + int'(w_rst === 1'b1);
      n_wake <= n_wake + int'(w_wake === 1'b1);
      n_res <= n_res + int'(resume === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge mclk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 d = rdata;
      check(d, exp);
   endtask : rd

   task automatic pulse(input int k);
      @(posedge mclk);
      clr_i <= (k == 1);
      sleep_i <= (k == 2);
      wake_i <= (k == 5);
      @(posedge mclk);
      {clr_i, sleep_i, wake_i} <= 3'h0;
   endtask : pulse

   task automatic do_reset;
      @(posedge mclk);
      rst <= 1'b1;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      step(3);
   endtask : do_reset

   // Kinds: 0 plain, 1 clear, 2 sleep instr, 3 freq write, 4 asleep
   task automatic run_wdt(input int kind, input int exp);
      int s, r0, w0;
      logic c;
      if (kind == 4) pm <= PM_SLEEP;
      pulse(1);
      s = lf_cnt;
      r0 = n_rst;
      w0 = n_wake;
      c = 1'b0;
      for (int i = 0; i < 20000 && n_rst == r0 && n_wake == w0; i++) begin
         @(posedge mclk);
         if (!c && kind > 0 && kind < 4 && lf_cnt - s == 60) begin
            c = 1'b1;
            if (kind == 3) wr(REG_OSC_CTRL, 8'h30);
            else pulse(kind);
         end
      end
      check(lf_cnt - s >= exp - 3 && lf_cnt - s <= exp + 3, 1);
      check(n_wake - w0, kind == 4);
      check(n_rst - r0, kind != 4);
      pm <= PM_RUN;
      step(3);
      check(irq, 1);
      wr(REG_INT_STATUS, 8'h02);
      step(2);
      check(irq, 0);
   endtask : run_wdt

   task automatic tally_and_finish;
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      do_reset();
      check(src, CLK_PRIMARY);
      check(lf_en, 0);
      rd(REG_OSC_CTRL, 8'h48);
      rd(REG_WDT_SOFT, 8'h00);
      rd(REG_INT_STATUS, 8'h00);
      rd(REG_INT_MASK, 8'h00);
      wr(REG_WDT_SOFT, 8'h01);
      wr(REG_INT_MASK, 8'h02);
      step(2);
      check(lf_en, 1);
      rd(REG_WDT_SOFT, 8'h01);
      for (int k = 0; k < 5; k++) begin
         run_wdt(k, (k > 0 && k < 4) ? 184 : 124);
      end
      cfg.wdt_tap <= 4'h1;
      run_wdt(0, 248);
      wr(REG_WDT_SOFT, 8'h00);
      pulse(1);
      d = 8'(n_rst);
      step(2500);
      check(n_rst - d, 0);
      check(lf_en, 0);
      cfg <= '{MODE_EXTERNAL_CLOCK, 1'b1, 4'h0, 1'b1};
      do_reset();
      check(lf_en, 1);
      wr(REG_INT_MASK, 8'h02);
      run_wdt(0, 124);
      do_reset();
      wr(REG_INT_MASK, 8'h01);
      pm <= PM_IDLE;
      prim_run <= 1'b0;
      step(40);
      check(src, CLK_INTERNAL);
      check(irq, 1);
      rd(REG_INT_STATUS, 8'h01);
      prim_run <= 1'b1;
      step(40);
      check(src, CLK_INTERNAL);
      pm <= PM_RUN;
      do_reset();
      pm <= PM_IDLE;
      step(3);
      check(src, CLK_PRIMARY);
      prim_run <= 1'b0;
      step(40);
      check(src, CLK_PRIMARY);
      check(irq, 0);
      d = 8'(n_res);
      pulse(5);
      step(3);
      check(n_res - d, 1);
      check(src, CLK_INTERNAL);
      pm <= PM_RUN;
      cfg.osc_mode <= MODE_HIGH_SPEED_CRYSTAL;
      do_reset();
      step(400);
      check(src, CLK_INTERNAL);
      rd(REG_INT_STATUS, 8'h00);
      rd(REG_OSC_CTRL, 8'h40);
      prim_run <= 1'b1;
      step(20);
      check(src, CLK_INTERNAL);
      ost_done <= 1'b1;
      step(40);
      check(src, CLK_PRIMARY);
      rd(REG_OSC_CTRL, 8'h48);
      ost_done <= 1'b0;
      do_reset();
      check(prim_en, 1);
      wr(REG_OSC_CTRL, 8'h42);
      step(3);
      check(prim_en, 0);
      wr(REG_OSC_CTRL, 8'h41);
      step(40);
      check(src, CLK_SECONDARY);
      rd(REG_INT_STATUS, 8'h00);
      tally_and_finish();
   end
endmodule : tb
